// ==== rtl/adc_sample_pkg.sv ====
// constants shared by the converter output port
// assumes one sample clock domain at the link and one reference clock domain
package adc_sample_pkg;
  localparam int          WORD_W       = 12;
  localparam int          MSB          = WORD_W - 1;
  localparam int          PIPE_DEPTH   = 4;
  localparam int          FILL_W       = 3;
  localparam logic [2:0]  FILL_LAST    = 3'h3;
  localparam logic [2:0]  FILL_ZERO    = 3'h0;
  localparam logic [2:0]  FILL_STEP    = 3'h1;
  localparam logic [11:0] CODE_MIN     = 12'h000;
  localparam logic [11:0] CODE_MAX     = 12'hfff;
  localparam logic [11:0] WORD_RESET   = 12'h000;
  // four-level strap, as delivered by the pin level detector
  localparam logic [1:0]  LEVEL_GND    = 2'h0;
  localparam logic [1:0]  LEVEL_THIRD  = 2'h1;
  localparam logic [1:0]  LEVEL_TWO3RD = 2'h2;
  localparam logic [1:0]  LEVEL_SUPPLY = 2'h3;
  typedef enum logic [1:0] {CONV_SLEEP, CONV_FILL, CONV_RUN} conv_state_type;
endpackage : adc_sample_pkg

// ==== rtl/adc_sample_output_port.sv ====
// digital output side of a pipelined 12-bit converter: straps, power-down,
// sample pipeline, format and data-ready strobe
// assumes the analog front end presents a code plus range flags at sample_clk
`timescale 1ns/1ps

module adc_sample_output_port (
  input  wire logic                                ref_clk,
  input  wire logic                                nrst,
  input  wire logic                                clk_en,
  input  wire logic                                sample_clk,
  input  wire logic [1:0]                          format_stabilizer_select,
  input  wire logic                                sleep_control,
  input  wire logic [adc_sample_pkg::WORD_W-1:0]   analog_code,
  input  wire logic                                analog_under,
  input  wire logic                                analog_over,
  output logic      [adc_sample_pkg::WORD_W-1:0]   sample_word_bits,
  output logic                                     output_word_strobe,
  output logic                                     output_format,
  output logic                                     duty_cycle_stabilizer,
  output logic                                     power_down,
  output logic                                     converting
);

  // ---------------- reference clock domain ----------------
  logic [1:0] fs_meta_reg;
  logic [1:0] fs_sync_reg;
  logic       slp_meta_reg;
  logic       slp_sync_reg;
  logic       run_meta_reg;
  logic       run_sync_reg;
  logic       fmt_reg;
  logic       dcs_reg;
  logic       pd_reg;
  logic       conv_reg;
  logic       run_flag_reg;
  logic       fmt_next;
  logic       dcs_next;

  // straps are static, so a per-bit two-flop crossing is enough
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      fs_meta_reg  <= adc_sample_pkg::LEVEL_GND;
      fs_sync_reg  <= adc_sample_pkg::LEVEL_GND;
      slp_meta_reg <= 1'b1;
      slp_sync_reg <= 1'b1;
    end else if (clk_en) begin
      fs_meta_reg  <= format_stabilizer_select;
      fs_sync_reg  <= fs_meta_reg;
      slp_meta_reg <= sleep_control;
      slp_sync_reg <= slp_meta_reg;
    end
  end

  always_comb begin
    fmt_next = (fs_sync_reg == adc_sample_pkg::LEVEL_SUPPLY) ||
               (fs_sync_reg == adc_sample_pkg::LEVEL_TWO3RD);
    dcs_next = (fs_sync_reg == adc_sample_pkg::LEVEL_TWO3RD) ||
               (fs_sync_reg == adc_sample_pkg::LEVEL_THIRD);
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      fmt_reg <= 1'b0;
      dcs_reg <= 1'b0;
      pd_reg  <= 1'b1;
    end else if (clk_en) begin
      fmt_reg <= fmt_next;
      dcs_reg <= dcs_next;
      pd_reg  <= slp_sync_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      run_meta_reg <= 1'b0;
      run_sync_reg <= 1'b0;
      conv_reg     <= 1'b0;
    end else if (clk_en) begin
      run_meta_reg <= run_flag_reg;
      run_sync_reg <= run_meta_reg;
      conv_reg     <= run_sync_reg;
    end
  end

  assign output_format         = fmt_reg;
  assign duty_cycle_stabilizer = dcs_reg;
  assign power_down            = pd_reg;
  assign converting            = conv_reg;

  fmt_twos_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_en && fs_sync_reg == adc_sample_pkg::LEVEL_TWO3RD |=> output_format)
    else $error("two-thirds strap did not select two's complement");
  fmt_binary_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_en && fs_sync_reg == adc_sample_pkg::LEVEL_THIRD |=> !output_format)
    else $error("one-third strap did not select offset binary");
  dcs_level_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_en && $stable(fs_sync_reg) |=>
      duty_cycle_stabilizer == ($past(fs_sync_reg[0]) ^ $past(fs_sync_reg[1])))
    else $error("stabilizer does not follow strap level");

  // ---------------- sample clock domain ----------------
  logic                               srst_meta_reg;
  logic                               srst_sync_reg;
  logic                               en_meta_reg;
  logic                               en_sync_reg;
  logic                               fmt_meta_reg;
  logic                               fmt_sync_reg;
  logic                               pdn_meta_reg;
  logic                               pdn_sync_reg;
  adc_sample_pkg::conv_state_type     state_reg;
  adc_sample_pkg::conv_state_type     state_next;
  logic [adc_sample_pkg::FILL_W-1:0]  fill_reg;
  logic [adc_sample_pkg::WORD_W-1:0]  pipe_reg [adc_sample_pkg::PIPE_DEPTH];
  logic [adc_sample_pkg::WORD_W-1:0]  clamped;
  logic [adc_sample_pkg::WORD_W-1:0]  pipe_last;
  logic [adc_sample_pkg::WORD_W-1:0]  word_reg;
  logic [adc_sample_pkg::WORD_W-1:0]  word_next;
  logic                               rise_tog_reg;
  logic                               fall_tog_reg;
  logic                               ce;
  logic                               sampling;

  // reset, enable, format and power-down levels cross into the link domain; the stabilizer decode stays in the reference domain
  always_ff @(posedge sample_clk) begin
    srst_meta_reg <= nrst;
    srst_sync_reg <= srst_meta_reg;
    en_meta_reg   <= clk_en;
    en_sync_reg   <= en_meta_reg;
    fmt_meta_reg  <= fmt_reg;
    fmt_sync_reg  <= fmt_meta_reg;
    pdn_meta_reg  <= pd_reg;
    pdn_sync_reg  <= pdn_meta_reg;
  end

  assign ce       = en_sync_reg;
  assign sampling = ce && state_reg != adc_sample_pkg::CONV_SLEEP;
  assign pipe_last = pipe_reg[adc_sample_pkg::PIPE_DEPTH-1];

  always_comb begin
    clamped = analog_code;
    if (analog_under) begin
      clamped = adc_sample_pkg::CODE_MIN;
    end else if (analog_over) begin
      clamped = adc_sample_pkg::CODE_MAX;
    end
  end

  // two's complement is offset binary with the msb inverted
  always_comb begin
    word_next = pipe_last;
    if (fmt_sync_reg) begin
      word_next[adc_sample_pkg::MSB] = ~pipe_last[adc_sample_pkg::MSB];
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      adc_sample_pkg::CONV_SLEEP: begin
        if (!pdn_sync_reg) begin
          state_next = adc_sample_pkg::CONV_FILL;
        end
      end
      adc_sample_pkg::CONV_FILL: begin
        if (pdn_sync_reg) begin
          state_next = adc_sample_pkg::CONV_SLEEP;
        end else if (fill_reg == adc_sample_pkg::FILL_LAST) begin
          state_next = adc_sample_pkg::CONV_RUN;
        end
      end
      adc_sample_pkg::CONV_RUN: begin
        if (pdn_sync_reg) begin
          state_next = adc_sample_pkg::CONV_SLEEP;
        end
      end
      default: state_next = adc_sample_pkg::CONV_SLEEP;
    endcase
  end

  // run flag is a flop, so the crossing never sees a state decode glitch
  always_ff @(posedge sample_clk) begin
    if (!srst_sync_reg) begin
      state_reg    <= adc_sample_pkg::CONV_SLEEP;
      run_flag_reg <= 1'b0;
    end else if (ce) begin
      state_reg    <= state_next;
      run_flag_reg <= state_next == adc_sample_pkg::CONV_RUN;
    end
  end

  // no strobe until the pipeline holds real samples after wake-up
  always_ff @(posedge sample_clk) begin
    if (!srst_sync_reg) begin
      fill_reg <= adc_sample_pkg::FILL_ZERO;
    end else if (ce) begin
      if (state_reg == adc_sample_pkg::CONV_FILL) begin
        fill_reg <= fill_reg + adc_sample_pkg::FILL_STEP;
      end else begin
        fill_reg <= adc_sample_pkg::FILL_ZERO;
      end
    end
  end

  always_ff @(posedge sample_clk) begin
    if (!srst_sync_reg) begin
      pipe_reg[0] <= adc_sample_pkg::WORD_RESET;
    end else if (sampling) begin
      pipe_reg[0] <= clamped;
    end
  end

  for (genvar i = 1; i < adc_sample_pkg::PIPE_DEPTH; i++) begin : g_pipe
    always_ff @(posedge sample_clk) begin
      if (!srst_sync_reg) begin
        pipe_reg[i] <= adc_sample_pkg::WORD_RESET;
      end else if (sampling) begin
        pipe_reg[i] <= pipe_reg[i-1];
      end
    end
  end

  // word and strobe fall move on the same edge, so data is settled at the rise
  always_ff @(posedge sample_clk) begin
    if (!srst_sync_reg) begin
      word_reg     <= adc_sample_pkg::WORD_RESET;
      rise_tog_reg <= 1'b0;
    end else if (ce && state_reg == adc_sample_pkg::CONV_RUN) begin
      word_reg     <= word_next;
      rise_tog_reg <= ~rise_tog_reg;
    end
  end

  // strobe is the xor of two edge toggles: glitch-free, full clock rate
  always_ff @(negedge sample_clk) begin
    if (!srst_sync_reg) begin
      fall_tog_reg <= 1'b0;
    end else if (ce) begin
      fall_tog_reg <= ~rise_tog_reg;
    end
  end

  assign sample_word_bits   = word_reg;
  assign output_word_strobe = rise_tog_reg ^ fall_tog_reg;

  sample_edge_a: assert property (@(posedge sample_clk) disable iff (!srst_sync_reg)
    sampling |=> pipe_reg[0] == $past(clamped))
    else $error("sample not taken on rising edge");
  sleep_freeze_a: assert property (@(posedge sample_clk) disable iff (!srst_sync_reg)
    ce && pdn_sync_reg |=> state_reg == adc_sample_pkg::CONV_SLEEP ##1 $stable(word_reg))
    else $error("conversion continued in power-down");
  lsb_order_a: assert property (@(posedge sample_clk) disable iff (!srst_sync_reg)
    ce && state_reg == adc_sample_pkg::CONV_RUN |=>
      sample_word_bits[adc_sample_pkg::MSB-1:0] == $past(pipe_last[adc_sample_pkg::MSB-1:0]))
    else $error("word bit order wrong");
  word_at_fall_a: assert property (@(negedge sample_clk) disable iff (!srst_sync_reg)
    $changed(word_reg) |-> $changed(rise_tog_reg) && !output_word_strobe)
    else $error("word changed away from strobe fall");
  strobe_high_a: assert property (@(posedge sample_clk) disable iff (!srst_sync_reg)
    ce && $past(ce) && $past(state_reg == adc_sample_pkg::CONV_RUN) ##0
      state_reg == adc_sample_pkg::CONV_RUN |-> output_word_strobe)
    else $error("strobe missed its high phase");
  clamp_over_a: assert property (@(posedge sample_clk) disable iff (!srst_sync_reg)
    sampling && analog_over && !analog_under |=> pipe_reg[0] == adc_sample_pkg::CODE_MAX)
    else $error("over range not clamped to 4095");
  clamp_under_a: assert property (@(posedge sample_clk) disable iff (!srst_sync_reg)
    sampling && analog_under |=> pipe_reg[0] == adc_sample_pkg::CODE_MIN)
    else $error("under range not clamped to zero");
  msb_invert_a: assert property (@(posedge sample_clk) disable iff (!srst_sync_reg)
    ce && state_reg == adc_sample_pkg::CONV_RUN |=>
      word_reg[adc_sample_pkg::MSB] ==
        ($past(pipe_last[adc_sample_pkg::MSB]) ^ $past(fmt_sync_reg)))
    else $error("msb not inverted for two's complement");

endmodule : adc_sample_output_port

// ==== verif/adc_capture_model.sv ====
// capture logic on the far side of the converter output port
// assumes the word is settled at each rising edge of the data-ready strobe
`timescale 1ns/1ps

module adc_capture_model (
  input  wire logic [adc_sample_pkg::WORD_W-1:0] sample_word_bits,
  input  wire logic                              output_word_strobe,
  output logic      [adc_sample_pkg::WORD_W-1:0] captured_word,
  output int                                     capture_count
);
  initial begin
    captured_word = adc_sample_pkg::WORD_RESET;
    capture_count = 0;
  end

  // latch on strobe rise, where the word is mid-period and stable
  always @(posedge output_word_strobe) begin
    captured_word = sample_word_bits;
    capture_count = capture_count + 1;
  end
endmodule : adc_capture_model

// ==== verif/adc_sample_output_port_bench.sv ====
// self-checking bench for the converter output port
// assumes the capture model as far side and a free-running 80 ns sample clock
`timescale 1ns/1ps

module adc_sample_output_port_bench;
  logic        ref_clk, nrst, clk_en, sample_clk, sleep_control, analog_under, analog_over;
  logic [1:0]  format_stabilizer_select;
  logic [11:0] analog_code, sample_word_bits, captured_word, exp_word;
  logic        output_word_strobe, output_format, duty_cycle_stabilizer;
  logic        power_down, converting;
  logic [31:0] r;
  int          failures, samples_checked, capture_count, snap;
  logic [11:0] exp_q[$];

  adc_sample_output_port dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .sample_clk(sample_clk),
    .format_stabilizer_select(format_stabilizer_select), .sleep_control(sleep_control),
    .analog_code(analog_code), .analog_under(analog_under), .analog_over(analog_over),
    .sample_word_bits(sample_word_bits), .output_word_strobe(output_word_strobe),
    .output_format(output_format), .duty_cycle_stabilizer(duty_cycle_stabilizer),
    .power_down(power_down), .converting(converting));

  adc_capture_model far_u (
    .sample_word_bits(sample_word_bits), .output_word_strobe(output_word_strobe),
    .captured_word(captured_word), .capture_count(capture_count));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // 50 percent duty, inside both duty windows; odd start offset keeps phase unrelated
  initial begin
    sample_clk = 1'b0;
    #23;
    forever #40 sample_clk = ~sample_clk;
  end

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  function automatic logic [11:0] fmt_word(input logic [11:0] c, input logic u, o, f);
    logic [11:0] v;
    v = u ? adc_sample_pkg::CODE_MIN : (o ? adc_sample_pkg::CODE_MAX : c);
    return f ? (v ^ 12'h800) : v;
  endfunction : fmt_word

  // random front-end codes, flags now and then
  always @(negedge sample_clk) begin
    r = $urandom;
    analog_code  <= r[11:0];
    analog_under <= (r[19:16] == 4'h0);
    analog_over  <= (r[23:20] == 4'h0);
  end

  // one note per sampling edge; strap only moves while asleep
  always @(posedge sample_clk) begin
    exp_q.push_back(fmt_word(analog_code, analog_under, analog_over,
                             format_stabilizer_select[1]));
  end

  // word seen at strobe rise is the sample taken four edges before the launching edge
  always @(capture_count) begin
    if (converting === 1'b1) begin
      while (exp_q.size() > 5) void'(exp_q.pop_front());
      exp_word = exp_q.pop_front();
      check(captured_word, exp_word);
    end
  end

  always @(sample_word_bits) begin
    if (nrst === 1'b1) begin
      #1;
      check({11'h0, output_word_strobe}, 12'h000);
    end
  end

  initial begin
    #200000;
    failures++;
    results();
  end

  initial begin
    failures = 0;
    samples_checked = 0;
    nrst = 1'b0;
    clk_en = 1'b1;
    sleep_control = 1'b1;
    format_stabilizer_select = adc_sample_pkg::LEVEL_GND;
    analog_code = 12'h000;
    analog_under = 1'b0;
    analog_over = 1'b0;
    void'($urandom(32'hbc39));
    repeat (10) @(negedge ref_clk);
    check({11'h0, power_down}, 12'h001);
    nrst = 1'b1;
    for (int lvl = 0; lvl < 4; lvl++) begin
      format_stabilizer_select = lvl[1:0];
      repeat (6) @(negedge ref_clk);
      check({11'h0, output_format}, {11'h0, lvl >= 2});
      check({11'h0, duty_cycle_stabilizer}, {11'h0, lvl == 1 || lvl == 2});
      sleep_control = 1'b0;
      repeat (40) @(negedge ref_clk);
      check({11'h0, power_down}, 12'h000);
      check({11'h0, converting}, 12'h001);
      @(posedge sample_clk);
      snap = capture_count;
      repeat (16) @(posedge sample_clk);
      check(12'(capture_count - snap), 12'h010);
      @(negedge ref_clk);
      sleep_control = 1'b1;
      repeat (20) @(negedge ref_clk);
      snap = capture_count;
      repeat (20) @(negedge ref_clk);
      check(12'(capture_count - snap), 12'h000);
      check({11'h0, power_down}, 12'h001);
    end
    results();
  end
endmodule : adc_sample_output_port_bench
